/* logic/adcc_cfg.svh */
// Constants for the converter control block: offsets, fields, reset values and timing counts.
// How it works
// - Conversions may run only while the converter enable bit 7 is set.
// - Clearing the enable is ignored while the start or done flag is set.
// - Bit 6 set turns on the second DAC analog output.
// - Bit 5 turns on the first DAC; writable only while start and done are clear.
// - Clock select bit 2 clear, the default, clocks the converter from CPU clock.
// - On CPU clock a conversion ends 31 machine cycles after the start request.
// - Clock select bit 2 set clocks the converter from the RC oscillator.
// - RC clocking spends 3 or 4 machine cycles synchronizing the two clocks; in power-down the code ends sync on the first RC clock.
// - RC conversion takes 3 cycles plus 108 RC clocks up to 4 plus 108; in power-down the sync part can be shorter.
// - RC clocked conversions carry on through CPU power-down.
// - Start stays set until completion, then clears, done sets and result loads; a power-down abort of a CPU clocked run clears only start.
// - The channel field cannot change while a conversion is in progress.
// - A set done flag requests an interrupt when both interrupt enables are on.
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH

// Control register address and field positions.
`define ADCC_CTRL_ADDR 8'hc0
`define ADCC_CTRL_RESET 8'h00
`define ADCC_BIT_ENABLE 7
`define ADCC_BIT_DAC2 6
`define ADCC_BIT_SECOND_DAC_VALUE 5
`define ADCC_BIT_DONE 4
`define ADCC_BIT_START 3
`define ADCC_BIT_RCSEL 2
`define ADCC_BIT_CHAN_HI 1
`define ADCC_BIT_CHAN_LO 0

// Timing counts.
`define ADCC_CPU_CONV_MCYC 8'h1f
`define ADCC_SYNC_MIN_MCYC 3'h3
`define ADCC_SYNC_MAX_MCYC 3'h4
`define ADCC_RC_CONV_CLKS 8'h6c
`define ADCC_SETTLE_US 10
`define ADCC_CLK_PERIOD_NS 20
`define ADCC_SETTLE_CYC ((`ADCC_SETTLE_US * 1000 + `ADCC_CLK_PERIOD_NS - 1) / `ADCC_CLK_PERIOD_NS)

`endif

/* logic/adcc_pkg.sv */
// Types shared by the converter control block.
package adcc_pkg;

    // Gray coded along idle, sync, convert.
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SYNC = 2'b01,
        ADCC_CONV = 2'b11
    } adcc_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic run;
        logic expired;
    } adcc_tmr_state_t;

    typedef struct packed {
        adcc_state_t state;
        logic enable;
        logic dac2;
        logic second_dac_value;
        logic done;
        logic start;
        logic rc_sel;
        logic [1:0] chan;
        logic [2:0] sync_cnt;
        logic [7:0] result;
        logic [7:0] rdata;
        logic sar_start;
    } adcc_ctl_state_t;

endpackage

/* logic/adcc_timer.sv */
// Tick counter that pulses once after a loaded number of ticks.
`timescale 1ns/1ps
`default_nettype none
module adcc_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Sequencer side
    adcc_tmr_if.timer tmr
);
    adcc_pkg::adcc_tmr_state_t st_r;
    adcc_pkg::adcc_tmr_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        if (tmr.load) begin
            st_nxt.count = 8'h00;
            st_nxt.run = 1'b1;
        end else if (st_r.run && tmr.tick) begin
            if (st_r.count == tmr.limit - 8'h01) begin
                st_nxt.run = 1'b0;
                st_nxt.expired = 1'b1;
            end else begin
                st_nxt.count = st_r.count + 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tmr.expired = st_r.expired;
endmodule
`default_nettype wire

/* logic/adcc_tmr_if.sv */
// Link between the conversion sequencer and its cycle timer.
`timescale 1ns/1ps
`default_nettype none
interface adcc_tmr_if;
    logic load;
    logic tick;
    logic [7:0] limit;
    logic expired;
    modport timer (input load, input tick, input limit, output expired);
    modport ctrl (output load, output tick, output limit, input expired);
endinterface
`default_nettype wire

/* logic/adcc_top.sv */
// Control register, start and done handshake and conversion timing of the converter.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_cfg.svh"
module adcc_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Special function register access
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Timing references and power state
    input wire logic mcyc_tick,
    input wire logic rc_tick,
    input wire logic power_down,
    // Interrupt gating
    input wire logic global_irq_enable,
    input wire logic converter_irq_enable,
    output logic irq_request,
    // Analog core
    input wire logic [7:0] sar_result,
    output logic sar_start,
    output logic converter_enable,
    output logic converter_clk_rc,
    output logic [1:0] channel_select,
    output logic [3:0] analog_input_sel,
    output logic conversion_busy,
    output logic [7:0] result_register,
    // DAC output enables
    output logic first_dac_enable,
    output logic second_dac_enable
);
    // ************************************************************
    // State
    // ************************************************************
    adcc_pkg::adcc_ctl_state_t st_r;
    adcc_pkg::adcc_ctl_state_t st_nxt;
    adcc_tmr_if tmr ();
    logic ctrl_wr;
    logic ctrl_rd;
    logic start_req;
    logic finish;
    logic abort;
    logic sync_exit;
    logic flags_idle;
    logic start_rc;
    logic [7:0] ctrl_view;

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // One-hot input routing for the analog multiplexer.
    function automatic logic [3:0] chan_decode(input logic [1:0] chan);
        chan_decode = 4'h1 << chan;
    endfunction

    // True when the access addresses the control register.
    function automatic logic hits_ctrl(input logic [7:0] addr);
        hits_ctrl = (addr == `ADCC_CTRL_ADDR);
    endfunction

    // Neither a conversion in flight nor an unread result: the locked fields may move.
    function automatic logic unlocked(input logic start, input logic done);
        unlocked = !start && !done;
    endfunction

    // ************************************************************
    // Cycle timer
    // ************************************************************
    adcc_timer u_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .tmr(tmr.timer)
    );

    // ************************************************************
    // Decode
    // ************************************************************
    assign ctrl_wr = sfr_wr && hits_ctrl(sfr_addr);
    assign ctrl_rd = sfr_rd && hits_ctrl(sfr_addr);
    assign flags_idle = unlocked(st_r.start, st_r.done);
    // The clock source of a new conversion comes from the same write that starts it.
    assign start_rc = sfr_wdata[`ADCC_BIT_RCSEL];

    // A start needs the converter enabled, no conversion running and no result pending.
    assign start_req = ctrl_wr && sfr_wdata[`ADCC_BIT_START] && st_r.enable
                       && flags_idle;

    // On CPU clock the core stops with the oscillator in power-down; RC clocked runs on.
    // The run is dropped rather than left hanging, and the result register keeps its value.
    assign abort = power_down && st_r.start && !st_r.rc_sel;

    // Only honoured while converting, so a pulse left over from an aborted run is harmless.
    assign finish = tmr.expired && (st_r.state == adcc_pkg::ADCC_CONV);

    // Sync ends on the first RC clock after three machine cycles, or at the fourth, or in power-down on any RC clock.
    assign sync_exit = (st_r.state == adcc_pkg::ADCC_SYNC)
                       && ((st_r.sync_cnt >= `ADCC_SYNC_MIN_MCYC && rc_tick)
                           || (st_r.sync_cnt == `ADCC_SYNC_MAX_MCYC)
                           || (power_down && rc_tick));

    assign ctrl_view = {st_r.enable, st_r.dac2, st_r.second_dac_value, st_r.done,
                        st_r.start, st_r.rc_sel, st_r.chan};

    // ************************************************************
    // Timer control
    // ************************************************************
    // The load follows the source chosen by the starting write, not the old select,
    // so a write that switches back to CPU clocking still arms the timer.
    always_comb begin
        tmr.load = sync_exit || (start_req && !start_rc);
        if (st_r.rc_sel) begin
            tmr.limit = `ADCC_RC_CONV_CLKS;
            tmr.tick = rc_tick;
        end else begin
            tmr.limit = `ADCC_CPU_CONV_MCYC;
            tmr.tick = mcyc_tick;
        end
    end

    // ************************************************************
    // Register and sequencer
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.sar_start = 1'b0;

        if (ctrl_rd) begin
            st_nxt.rdata = ctrl_view;
        end

        if (ctrl_wr) begin
            // Clearing the enable under a pending flag would cut power mid-handshake,
            // and a write that starts a conversion may not switch the converter off either.
            if (sfr_wdata[`ADCC_BIT_ENABLE] || (flags_idle && !start_req)) begin
                st_nxt.enable = sfr_wdata[`ADCC_BIT_ENABLE];
            end
            st_nxt.dac2 = sfr_wdata[`ADCC_BIT_DAC2];
            if (flags_idle) begin
                st_nxt.second_dac_value = sfr_wdata[`ADCC_BIT_SECOND_DAC_VALUE];
                st_nxt.chan = {sfr_wdata[`ADCC_BIT_CHAN_HI], sfr_wdata[`ADCC_BIT_CHAN_LO]};
                st_nxt.rc_sel = sfr_wdata[`ADCC_BIT_RCSEL];
            end
            // Software may only clear the done flag.
            if (!sfr_wdata[`ADCC_BIT_DONE]) begin
                st_nxt.done = 1'b0;
            end
        end

        unique case (st_r.state)
            adcc_pkg::ADCC_IDLE: begin
                if (start_req) begin
                    st_nxt.start = 1'b1;
                    st_nxt.sar_start = 1'b1;
                    st_nxt.sync_cnt = 3'h0;
                    if (start_rc) begin
                        st_nxt.state = adcc_pkg::ADCC_SYNC;
                    end else begin
                        st_nxt.state = adcc_pkg::ADCC_CONV;
                    end
                end
            end
            adcc_pkg::ADCC_SYNC: begin
                if (sync_exit) begin
                    st_nxt.state = adcc_pkg::ADCC_CONV;
                end else if (mcyc_tick) begin
                    st_nxt.sync_cnt = st_r.sync_cnt + 3'h1;
                end
            end
            adcc_pkg::ADCC_CONV: begin
                if (finish) begin
                    st_nxt.state = adcc_pkg::ADCC_IDLE;
                    st_nxt.start = 1'b0;
                    st_nxt.result = sar_result;
                end
            end
        endcase

        // The completion event outranks a software clear in the same cycle.
        if (finish) begin
            st_nxt.done = 1'b1;
        end

        if (abort) begin
            st_nxt.state = adcc_pkg::ADCC_IDLE;
            st_nxt.start = 1'b0;
        end
    end

    // Synchronous reset clears every field, so the control register reads zero afterwards.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Data outputs come straight from flops of the state struct, except analog_input_sel, decoded from the channel, and irq_request, gated by both interrupt enables.
    assign sfr_rdata = st_r.rdata;
    assign sar_start = st_r.sar_start;
    assign converter_enable = st_r.enable;
    assign converter_clk_rc = st_r.rc_sel;
    assign channel_select = st_r.chan;
    assign analog_input_sel = chan_decode(st_r.chan);
    assign conversion_busy = st_r.start;
    assign result_register = st_r.result;
    assign first_dac_enable = st_r.second_dac_value;
    assign second_dac_enable = st_r.dac2;
    // Priority among pending sources is resolved by the interrupt controller.
    assign irq_request = st_r.done && global_irq_enable && converter_irq_enable;
endmodule
`default_nettype wire

/* tb/adc_conversion_control_test.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_test;
    logic sys_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, rd_seen = 0;
    logic mcyc_tick = 0, rc_tick = 0, power_down = 0;
    logic global_irq_enable = 0, converter_irq_enable = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sar_result = 8'h00, c, old;
    wire logic [7:0] sfr_rdata, result_register;
    wire logic [3:0] analog_input_sel;
    wire logic [1:0] channel_select;
    wire logic irq_request, sar_start, converter_enable, converter_clk_rc;
    wire logic conversion_busy, first_dac_enable, second_dac_enable;
    logic [7:0] exp_q[$];
    int errors = 0, n_compared = 0, cyc = 0, seed = 32'h294714c6;
    adcc_top DUT (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .mcyc_tick(mcyc_tick),
        .rc_tick(rc_tick),
        .power_down(power_down),
        .global_irq_enable(global_irq_enable),
        .converter_irq_enable(converter_irq_enable),
        .irq_request(irq_request),
        .sar_result(sar_result),
        .sar_start(sar_start),
        .converter_enable(converter_enable),
        .converter_clk_rc(converter_clk_rc),
        .channel_select(channel_select),
        .analog_input_sel(analog_input_sel),
        .conversion_busy(conversion_busy),
        .result_register(result_register),
        .first_dac_enable(first_dac_enable),
        .second_dac_enable(second_dac_enable)
    );
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    // ****
    // Timing references and read watcher
    // ****
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        mcyc_tick <= #1 cyc % 4 == 0;
        rc_tick <= #1 cyc % 3 == 1;
        rd_seen <= sfr_rd;
    end
    always @(negedge sys_clk) begin
        if (rd_seen)
            chk(sfr_rdata, exp_q.pop_front());
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk) #1;
        sfr_addr = 8'hc0;
        sfr_wdata = d;
        sfr_wr = 1;
        @(posedge sys_clk) #1 sfr_wr = 0;
        @(posedge sys_clk) #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) #1;
        sfr_addr = a;
        sfr_rd = 1;
        exp_q.push_back(e);
        @(posedge sys_clk) #1 sfr_rd = 0;
    endtask
    task automatic wait_done(input int lim);
        int i;
        for (i = 0; i < lim && conversion_busy !== 1'b0; i++)
            @(posedge sys_clk) #1;
        if (i == lim) begin
            errors++;
            summarize();
        end
    endtask
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst_b = 1;
        rd(8'hc0, 8'h00);
        wr(8'h80);
        repeat (500) @(posedge sys_clk);
        rd(8'h55, 8'h00);
        rd(8'hc0, 8'h80);
        for (c = 0; c < 4; c++) begin
            sar_result = 8'($random(seed));
            global_irq_enable = c[0];
            converter_irq_enable = c[1];
            wr(8'h88 | c);
            chk({4'h0, analog_input_sel}, 8'h01 << c);
            rd(8'hc0, 8'h88 | c);
            wr(8'h23);
            rd(8'hc0, 8'h88 | c);
            wait_done(200);
            rd(8'hc0, 8'h90 | c);
            chk(result_register, sar_result);
            chk({7'h00, irq_request}, {7'h00, c[0] & c[1]});
            wr(8'h98 | c);
            rd(8'hc0, 8'h90 | c);
            wr(8'h80 | (c ^ 8'h01));
            rd(8'hc0, 8'h80 | c);
        end
        // Power-down during an RC clocked conversion, then during a CPU clocked one that it aborts.
        sar_result = 8'($random(seed));
        wr(8'h8e);
        power_down = 1;
        wait_done(1000);
        power_down = 0;
        chk(result_register, sar_result);
        rd(8'hc0, 8'h96);
        chk({7'h00, converter_clk_rc}, 8'h01);
        wr(8'h86);
        wr(8'h80);
        old = sar_result;
        sar_result = 8'($random(seed));
        wr(8'h88);
        power_down = 1;
        wait_done(20);
        power_down = 0;
        rd(8'hc0, 8'h80);
        chk(result_register, old);
        wr(8'h40);
        wr(8'h48);
        rd(8'hc0, 8'h40);
        chk({7'h00, second_dac_enable}, 8'h01);
        wr(8'h20);
        rd(8'hc0, 8'h20);
        chk({7'h00, first_dac_enable}, 8'h01);
        repeat (2) @(posedge sys_clk);
        summarize();
    end
endmodule
`default_nettype wire

/* tb/adcc_top_asserts.sv */
// Port checker for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Inputs
    input wire logic mcyc_tick,
    input wire logic power_down,
    input wire logic global_irq_enable,
    input wire logic converter_irq_enable,
    // Outputs
    input wire logic irq_request,
    input wire logic sar_start,
    input wire logic converter_enable,
    input wire logic converter_clk_rc,
    input wire logic [1:0] channel_select,
    input wire logic conversion_busy,
    input wire logic [7:0] result_register,
    input wire logic first_dac_enable
);
    // ****
    // Machine cycles of the running conversion.
    // ****
    // The timer ignores a tick on the loading edge, so counting starts at the edge that sees the start pulse.
    logic [7:0] ticks_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            ticks_r <= 8'h00;
        else if (sar_start)
            ticks_r <= 8'(mcyc_tick);
        else if (conversion_busy && mcyc_tick)
            ticks_r <= ticks_r + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_irq; irq_request |-> global_irq_enable && converter_irq_enable; endproperty
    a_irq: assert property (p_irq) else $error("irq ungated");
    property p_go; $rose(conversion_busy) |-> sar_start && converter_enable; endproperty
    a_go: assert property (p_go) else $error("bad start");
    property p_pulse; sar_start |=> !sar_start; endproperty
    a_pulse: assert property (p_pulse) else $error("long start pulse");
    property p_en; conversion_busy |-> converter_enable; endproperty
    a_en: assert property (p_en) else $error("enable lost");
    property p_chan; conversion_busy && $past(conversion_busy) |-> $stable(channel_select); endproperty
    a_chan: assert property (p_chan) else $error("channel moved");
    property p_dac; conversion_busy && $past(conversion_busy) |-> $stable(first_dac_enable); endproperty
    a_dac: assert property (p_dac) else $error("dac moved");
    property p_res; $changed(result_register) |-> $past(conversion_busy) && !conversion_busy; endproperty
    a_res: assert property (p_res) else $error("result moved");
    property p_cpu;
        $fell(conversion_busy) && !converter_clk_rc && !$past(power_down) |-> ticks_r == 8'h1f;
    endproperty
    a_cpu: assert property (p_cpu) else $error("cpu time");
    c_cpu: cover property ($fell(conversion_busy) && !converter_clk_rc);
    c_rc: cover property ($fell(conversion_busy) && converter_clk_rc);
    c_irq: cover property ($rose(irq_request));
endmodule
bind adcc_top adcc_checker u_chk (.*);
`default_nettype wire
